// *** rtl/boot_loader_defs.svh ***
// Purpose: Timing counts, command bits and straps for the boot loader watchdog
// Assumes: 20 MHz block clock
// Notes:   Definitions only
`ifndef BOOT_LOADER_DEFS_SVH
`define BOOT_LOADER_DEFS_SVH

// Clock and time figures
`define CLK_PERIOD_NS      50
`define TICK_PERIOD_NS     1000000
`define TICK_CYCLES        (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define SYNC_DELAY_NS      100
`define SYNC_DELAY_CYCLES  ((`SYNC_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Watchdog timeout strap: timeout = (select + 1) * 16 ms
`define WD_STEP_TICKS      9'd16
`define WD_DEFAULT_SEL     4'h5

// Command byte bit positions, byte taken from data lines 15..8
`define CMD_BIT_LOAD       7
`define CMD_BIT_START      6
`define CMD_BIT_STOP       4
`define CMD_BIT_ADDR_CLR   2

// Byte lane of the data lines used for address, command and data
`define BYTE_HI            15
`define BYTE_LO            8

// Default unit address on the bus (value arbitrary)
`define UNIT_ADDR_DEFAULT  8'h24

`endif

// *** rtl/boot_loader_pkg.sv ***
// Purpose: Types shared by the boot loader watchdog design
// Assumes: Nothing
// Notes:   Constants live in boot_loader_defs.svh
package boot_loader_pkg;
	// Data request sequence
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ASSEMBLE,
		ST_DELAY,
		ST_SYNC
	} xfer_state_t;
	typedef logic [11:0] rom_addr_t;
	typedef logic [3:0]  rom_word_t;
endpackage

// *** rtl/rom_store.sv ***
// Purpose: Program store of sixteen 256 x 4 ROMs with chip select decode
// Assumes: Contents loaded through the write port before use
// Notes:   Read is combinational from the address
`timescale 1ns/1ns
`default_nettype none
module rom_store
	import boot_loader_pkg::*;
(
	// Clock
	input  wire logic      clock_in,
	// Programming port
	input  wire logic      wr_en_in,
	input  wire rom_addr_t wr_addr_in,
	input  wire rom_word_t wr_data_in,
	// Read port
	input  wire rom_addr_t rd_addr_in,
	output logic [15:0]    rom_chip_select_out,
	output rom_word_t      rd_word_out
);
	// One-hot select of the ROM named by the upper address bits
	function automatic logic [15:0] chip_decode(input logic [3:0] sel);
		chip_decode = 16'h0001 << sel;
	endfunction

	wire [15:0]     wr_select;
	rom_word_t      words [16];

	assign rom_chip_select_out = chip_decode(rd_addr_in[11:8]); // R18
	assign wr_select           = chip_decode(wr_addr_in[11:8]);

	////////////////////////////////////////////////////////////////////////////
	// One array per ROM position; unequipped positions simply read their array
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_rom
			rom_word_t mem [256];
			// Programming write, no reset on the storage
			always_ff @(posedge clock_in) begin
				if (wr_en_in && wr_select[g]) begin
					mem[wr_addr_in[7:0]] <= wr_data_in;
				end
			end
			assign words[g] = mem[rd_addr_in[7:0]]; // R18
		end
	endgenerate

	// Selected ROM drives the shared word bus
	assign rd_word_out = words[rd_addr_in[11:8]];
endmodule // rom_store
`default_nettype wire

// *** rtl/boot_rom_loader_watchdog.sv ***
// Purpose: Boot program store and watchdog on a multiplexed I/O bus
// Assumes: Bus and switch inputs asynchronous, shown active high
// Notes:   Byte served as two ROM words; watchdog ticks every 1 ms
`timescale 1ns/1ns
`default_nettype none
`include "boot_loader_defs.svh"

// Summary of operation
// R1: Address counter steps on request rise and fall
// R2: Sync reply waits until byte assembled
// R3: First word latched, joined with second word
// R4: Byte driven on data lines 15..8
// R5: Strobes answered only while unit selected
// R6: Software resets timer before each expiry
// R7: Watchdog counts 1 ms ticks, default 96
// R8: Timeout strap 16 to 256 ms, 16 steps
// R9: Enabled expiry asserts processor initialise
// R10: Disable switch makes unit invisible on bus
// R11: Forced initialise switch asserts initialise always
// R12: Expiry initialises only with enable switch on
// R13: Run flag starts timer, arms timeout flag
// R14: Command byte 40 starts tick oscillator
// R15: Timer reset command reloads all counters
// R16: System clear returns everything to start
// R17: 12-bit address counter cleared by bit 10
// R18: Sixteen ROMs of 256 four-bit words
// R19: Timeout and initialise held until reload
// R20: Tick from clock prescaler, parameter ratio
module boot_rom_loader_watchdog
	import boot_loader_pkg::*;
#(
	parameter int       TICK_DIV  = `TICK_CYCLES,
	parameter bit [7:0] UNIT_ADDR = `UNIT_ADDR_DEFAULT
)(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_in,
	input  wire logic        system_clear_in,
	// Processor bus strobes
	input  wire logic        bus_address_strobe_in,
	input  wire logic        bus_command_strobe_in,
	input  wire logic        bus_data_request_in,
	output logic             bus_sync_reply_out,
	// Processor data lines
	input  wire logic [15:0] bus_data_lines_in,
	output logic [15:0]      bus_data_lines_out,
	output logic             bus_data_lines_oe_out,
	// Switch panel and straps
	input  wire logic        unit_disable_in,
	input  wire logic        forced_init_in,
	input  wire logic        watchdog_enable_in,
	input  wire logic [3:0]  timeout_select_in,
	// ROM programming port
	input  wire logic        rom_wr_en_in,
	input  wire rom_addr_t   rom_wr_addr_in,
	input  wire rom_word_t   rom_wr_data_in,
	// Processor initialise and status
	output logic             processor_init_out,
	output logic             watchdog_timeout_out,
	output logic             watchdog_run_out
);
	localparam int SYNC_CNT = `SYNC_DELAY_CYCLES;

	////////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers for every bus, switch and strap pin (not the ROM programming port); a third stage for edge detect
	localparam int NSYNC = 8;
	logic [NSYNC-1:0] pins_meta_ff, pins_sync_ff, pins_last_ff;
	logic [15:0]      data_meta_ff, data_sync_ff;
	logic [3:0]       sel_meta_ff, sel_sync_ff;
	wire  [NSYNC-1:0] pins_raw = {system_clear_in, bus_address_strobe_in,
		bus_command_strobe_in, bus_data_request_in, unit_disable_in,
		forced_init_in, watchdog_enable_in, 1'b0};

	// Pin capture; first stage feeds only the second
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pins_meta_ff <= '0;
			pins_sync_ff <= '0;
			pins_last_ff <= '0;
			data_meta_ff <= '0;
			data_sync_ff <= '0;
			sel_meta_ff  <= `WD_DEFAULT_SEL;
			sel_sync_ff  <= `WD_DEFAULT_SEL;
		end else begin
			pins_meta_ff <= pins_raw;
			pins_sync_ff <= pins_meta_ff;
			pins_last_ff <= pins_sync_ff;
			data_meta_ff <= bus_data_lines_in;
			data_sync_ff <= data_meta_ff;
			sel_meta_ff  <= timeout_select_in;
			sel_sync_ff  <= sel_meta_ff;
		end
	end

	// Named synchronised levels and edges
	wire       sclr_s    = pins_sync_ff[7];
	wire       adrs_rise = pins_sync_ff[6] & ~pins_last_ff[6];
	wire       cmd_rise  = pins_sync_ff[5] & ~pins_last_ff[5];
	wire       dr_s      = pins_sync_ff[4];
	wire       dr_rise   = pins_sync_ff[4] & ~pins_last_ff[4];
	wire       dis_s     = pins_sync_ff[3];
	wire       forced_s  = pins_sync_ff[2];
	wire       enable_s  = pins_sync_ff[1];
	wire [7:0] bus_byte  = data_sync_ff[`BYTE_HI:`BYTE_LO];

	////////////////////////////////////////////////////////////////////////////
	// Address selection and gated strobes
	logic selected_ff;
	wire  gated_command_strobe = cmd_rise & selected_ff & ~dis_s; // R5
	wire  gated_data_request   = dr_rise & selected_ff & ~dis_s;  // R5
	wire  counter_load_pulse   = gated_command_strobe & bus_byte[`CMD_BIT_LOAD];
	wire  cmd_start            = gated_command_strobe & bus_byte[`CMD_BIT_START];
	wire  cmd_stop             = gated_command_strobe & bus_byte[`CMD_BIT_STOP];
	wire  cmd_addr_clr         = gated_command_strobe & bus_byte[`CMD_BIT_ADDR_CLR];

	// Selected flag follows each address strobe; disable hides the unit
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			selected_ff <= 1'b0;
		end else if (sclr_s || dis_s) begin // R10 R16
			selected_ff <= 1'b0;
		end else if (adrs_rise) begin
			selected_ff <= (bus_byte == UNIT_ADDR);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data request sequence and ROM address counter
	xfer_state_t state_ff, nxt_state;
	rom_addr_t   addr_ff;
	rom_word_t   hold_ff, rom_word;
	logic [7:0]  byte_ff;
	logic [1:0]  delay_ff;
	logic [15:0] rom_chip_select;
	wire         dr_gone = (state_ff != ST_IDLE) && !dr_s;
	wire         rom_addr_increment = (state_ff == ST_IDLE && gated_data_request) || dr_gone;

	rom_store u_rom_store (
		.clock_in            (clock_in),
		.wr_en_in            (rom_wr_en_in),
		.wr_addr_in          (rom_wr_addr_in),
		.wr_data_in          (rom_wr_data_in),
		.rd_addr_in          (addr_ff),
		.rom_chip_select_out (rom_chip_select),
		.rd_word_out         (rom_word)
	);

	// Next state: trailing edge of the request ends any transfer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE:     if (gated_data_request) nxt_state = ST_ASSEMBLE;
			ST_ASSEMBLE: nxt_state = dr_s ? ST_DELAY : ST_IDLE;
			ST_DELAY:    nxt_state = !dr_s ? ST_IDLE :
				(delay_ff == 2'(SYNC_CNT - 1)) ? ST_SYNC : ST_DELAY; // R2
			ST_SYNC:     if (!dr_s) nxt_state = ST_IDLE;
		endcase
	end

	// Sequence registers
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_ff <= ST_IDLE;
			delay_ff <= '0;
			hold_ff  <= '0;
			byte_ff  <= '0;
		end else if (sclr_s) begin // R16
			state_ff <= ST_IDLE;
			delay_ff <= '0;
			hold_ff  <= '0;
			byte_ff  <= '0;
		end else begin
			state_ff <= nxt_state;
			delay_ff <= (state_ff == ST_DELAY) ? delay_ff + 2'd1 : 2'd0;
			if (state_ff == ST_IDLE && gated_data_request) begin
				hold_ff <= rom_word; // R3
			end
			if (state_ff == ST_ASSEMBLE) begin
				byte_ff <= {hold_ff, rom_word}; // R3
			end
		end
	end

	// Address counter: clear wins over load, load over increment
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			addr_ff <= '0;
		end else if (sclr_s || cmd_addr_clr || counter_load_pulse) begin // R17 R15
			addr_ff <= '0;
		end else if (rom_addr_increment) begin
			addr_ff <= addr_ff + 12'd1; // R1
		end
	end

	// Byte sits on the upper lane while the sequence holds it
	assign bus_data_lines_oe_out = (state_ff == ST_DELAY) || (state_ff == ST_SYNC);
	assign bus_data_lines_out    = {byte_ff, 8'h00}; // R4
	assign bus_sync_reply_out    = (state_ff == ST_SYNC); // R2

	////////////////////////////////////////////////////////////////////////////
	// Watchdog: prescaler, tick counter, timeout flag
	logic [15:0] prescale_ff;
	logic [8:0]  ticks_ff;
	logic        tick_ff, watchdog_run_flag, expired_ff;
	wire  [8:0]  timeout_ticks = (9'(sel_sync_ff) + 9'd1) * `WD_STEP_TICKS; // R8
	wire         wd_reload     = sclr_s || counter_load_pulse;

	// Run flag: start command sets it, stop command clears it
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			watchdog_run_flag <= 1'b0;
		end else if (sclr_s || cmd_stop) begin
			watchdog_run_flag <= 1'b0;
		end else if (cmd_start) begin
			watchdog_run_flag <= 1'b1; // R13 R14
		end
	end

	// 1 ms tick enable; the oscillator only runs with the run flag
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			prescale_ff <= '0;
			tick_ff     <= 1'b0;
		end else if (wd_reload || !watchdog_run_flag) begin // R15
			prescale_ff <= '0;
			tick_ff     <= 1'b0;
		end else begin
			tick_ff     <= (prescale_ff == 16'(TICK_DIV - 1)); // R20
			prescale_ff <= (prescale_ff == 16'(TICK_DIV - 1)) ? 16'd0 : prescale_ff + 16'd1;
		end
	end

	// Tick count and sticky timeout
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ticks_ff   <= '0;
			expired_ff <= 1'b0;
		end else if (wd_reload) begin // R15 R16 R6
			ticks_ff   <= '0;
			expired_ff <= 1'b0;
		end else if (tick_ff && watchdog_run_flag && !expired_ff) begin
			ticks_ff   <= ticks_ff + 9'd1; // R7
			expired_ff <= (ticks_ff + 9'd1 >= timeout_ticks); // R13 R19
		end
	end

	// Initialise: forced switch, or expiry with enable switch
	assign processor_init_out   = forced_s || (expired_ff && enable_s); // R9 R11 R12
	assign watchdog_timeout_out = expired_ff;
	assign watchdog_run_out     = watchdog_run_flag;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	a_addr_rise_step: assert property (state_ff == ST_IDLE && gated_data_request // R1
		&& !sclr_s && !counter_load_pulse && !cmd_addr_clr
		|=> addr_ff == $past(addr_ff) + 12'd1)
		else $error("address not stepped on request rise");
	a_addr_fall_step: assert property (dr_gone && !sclr_s && !counter_load_pulse // R1
		&& !cmd_addr_clr |=> addr_ff == $past(addr_ff) + 12'd1)
		else $error("address not stepped on request fall");
	a_sync_after_byte: assert property ($rose(bus_sync_reply_out) // R2
		|-> $past(state_ff == ST_DELAY, 1) && bus_data_lines_oe_out)
		else $error("sync before byte assembled");
	a_byte_pairs_words: assert property (state_ff == ST_ASSEMBLE && !sclr_s // R3
		|=> byte_ff == {$past(hold_ff), $past(rom_word)})
		else $error("byte not built from two words");
	a_upper_lane_only: assert property (bus_data_lines_oe_out // R4
		|-> bus_data_lines_out[7:0] == 8'h00 && bus_data_lines_out[15:8] == byte_ff)
		else $error("byte on wrong lane");
	a_unselected_quiet: assert property (state_ff == ST_IDLE && !selected_ff // R5
		|=> state_ff == ST_IDLE)
		else $error("request answered while unselected");
	a_disable_hides: assert property (dis_s |=> !selected_ff) // R10
		else $error("unit selected while disabled");
	a_forced_init: assert property (forced_s |-> processor_init_out) // R11
		else $error("forced initialise not asserted");
	a_enable_gates: assert property (!forced_s && !enable_s |-> !processor_init_out) // R12
		else $error("initialise without enable");
	a_expiry_count: assert property (tick_ff && watchdog_run_flag && !expired_ff // R7 R8
		&& !wd_reload && ticks_ff == timeout_ticks - 9'd1 |=> expired_ff)
		else $error("watchdog missed expiry");
	a_start_cmd: assert property (cmd_start && !cmd_stop && !sclr_s // R14
		|=> watchdog_run_flag)
		else $error("start command ignored");
	a_reload_clears: assert property (counter_load_pulse // R15
		|=> ticks_ff == 9'd0 && addr_ff == 12'd0 && !expired_ff)
		else $error("reload left a counter");
	a_expiry_holds: assert property (expired_ff && !wd_reload |=> expired_ff) // R19
		else $error("timeout dropped without reload");
	a_tick_single: assert property (tick_ff |=> !tick_ff) // R20
		else $error("tick wider than one cycle");
	// Exactly one ROM enabled, the one the counter's upper bits name
	a_rom_select_onehot: assert property ($onehot(rom_chip_select) // R18
		&& rom_chip_select[addr_ff[11:8]])
		else $error("ROM select not one-hot on address");
endmodule // boot_rom_loader_watchdog
`default_nettype wire

// *** test/bus_processor_model.sv ***
// Purpose: Processor side of the multiplexed I/O bus for the boot loader
// Assumes: Strobes and data change on the falling clock edge
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module bus_processor_model (
	// Clock
	input  wire logic        clock_in,
	// Device side
	input  wire logic        sync_in,
	input  wire logic        dut_oe_in,
	input  wire logic [15:0] dut_data_in,
	// Processor strobes and resolved data lines
	output logic             adrs_out,
	output logic             cmd_out,
	output logic             dr_out,
	output logic [15:0]      data_out
);
	logic [15:0] drive_ff = 16'h0000;

	initial begin
		adrs_out = 1'b0;
		cmd_out = 1'b0;
		dr_out = 1'b0;
	end

	// Device wins the wire while it drives the byte lane
	assign data_out = dut_oe_in ? dut_data_in : drive_ff;

	// Byte set up 3 cycles early so the synchroniser sees it settled
	task automatic strobe(input logic [7:0] b, input logic is_cmd);
		@(negedge clock_in);
		drive_ff = {b, 8'h00};
		repeat (3) @(negedge clock_in);
		if (is_cmd) cmd_out = 1'b1;
		else adrs_out = 1'b1;
		repeat (4) @(negedge clock_in);
		cmd_out = 1'b0;
		adrs_out = 1'b0;
		repeat (4) @(negedge clock_in);
		drive_ff = ~drive_ff;
	endtask

	// Request held until sync is sampled high or 20 rising edges pass, byte taken at that edge
	task automatic read_byte(output logic [7:0] b, output logic ok);
		int n;
		ok = 1'b0;
		b = 8'h00;
		@(negedge clock_in);
		dr_out = 1'b1;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clock_in);
			if (sync_in === 1'b1) begin
				ok = 1'b1;
				b = data_out[15:8]; // Resolved lines, so a missing enable shows up
			end
		end
		@(negedge clock_in);
		dr_out = 1'b0;
		repeat (5) @(negedge clock_in);
	endtask
endmodule // bus_processor_model
`default_nettype wire

// *** test/boot_rom_loader_watchdog_tb.sv ***
// Purpose: Self-checking bench for the boot loader watchdog
// Assumes: Prescaler shortened to 4 cycles per tick
// Notes:   Processor bus driven through bus_processor_model
`timescale 1ns/1ns
`default_nettype none
module boot_rom_loader_watchdog_tb
	import boot_loader_pkg::*;
;
	localparam int DIV = 4;
	logic        clock_in = 1'b0, rst_in = 1'b1, system_clear_in = 1'b0;
	logic        unit_disable_in = 1'b0, forced_init_in = 1'b0, watchdog_enable_in = 1'b0;
	logic        rom_wr_en_in = 1'b0;
	logic [3:0]  timeout_select_in = 4'h5;
	rom_addr_t   rom_wr_addr_in = 12'h000;
	rom_word_t   rom_wr_data_in = 4'h0;
	wire logic   adrs, cmd, dr, sync, oe, init, tmo, run;
	wire logic [15:0] dl_in, dl_out;
	int          num_errors = 0, samples_checked = 0;
	logic [7:0]  b;
	logic        ok;

	boot_rom_loader_watchdog #(.TICK_DIV(DIV)) u_dut (.clock_in(clock_in), .rst_in(rst_in),
		.system_clear_in(system_clear_in), .bus_address_strobe_in(adrs),
		.bus_command_strobe_in(cmd), .bus_data_request_in(dr), .bus_sync_reply_out(sync),
		.bus_data_lines_in(dl_in), .bus_data_lines_out(dl_out), .bus_data_lines_oe_out(oe),
		.unit_disable_in(unit_disable_in), .forced_init_in(forced_init_in),
		.watchdog_enable_in(watchdog_enable_in), .timeout_select_in(timeout_select_in),
		.rom_wr_en_in(rom_wr_en_in), .rom_wr_addr_in(rom_wr_addr_in),
		.rom_wr_data_in(rom_wr_data_in), .processor_init_out(init),
		.watchdog_timeout_out(tmo), .watchdog_run_out(run));

	bus_processor_model u_cpu (.clock_in(clock_in), .sync_in(sync), .dut_oe_in(oe),
		.dut_data_in(dl_out), .adrs_out(adrs), .cmd_out(cmd), .dr_out(dr), .data_out(dl_in));

	////////////////////////////////////////////////////////////////////////
	// Clock and helpers
	initial begin
		forever #25 clock_in = ~clock_in;
	end

	function automatic rom_word_t pat(input int a);
		return 4'(a * 7 + 3);
	endfunction

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reads across the first ROM boundary, two words per byte
	task automatic t_read();
		for (int a = 0; a < 260; a++) begin
			@(negedge clock_in);
			rom_wr_en_in = 1'b1;
			rom_wr_addr_in = 12'(a);
			rom_wr_data_in = pat(a);
		end
		@(negedge clock_in);
		rom_wr_en_in = 1'b0;
		u_cpu.strobe(8'h24, 1'b0);
		u_cpu.strobe(8'h04, 1'b1);
		for (int k = 0; k < 130; k++) begin
			u_cpu.read_byte(b, ok);
			chk("sync", 16'h1, {15'h0, ok});
			chk("byte", {8'h00, pat(2 * k), pat(2 * k + 1)}, {8'h00, b});
		end
		u_cpu.strobe(8'h04, 1'b1);
		u_cpu.read_byte(b, ok);
		chk("byte after clear", {8'h00, pat(0), pat(1)}, {8'h00, b});
	endtask

	// Wrong address and disable switch both hide the unit
	task automatic t_select();
		u_cpu.strobe(8'h25, 1'b0);
		u_cpu.read_byte(b, ok);
		chk("sync unselected", 16'h0, {15'h0, ok});
		unit_disable_in = 1'b1;
		u_cpu.strobe(8'h24, 1'b0);
		u_cpu.read_byte(b, ok);
		chk("sync disabled", 16'h0, {15'h0, ok});
		unit_disable_in = 1'b0;
		u_cpu.strobe(8'h24, 1'b0);
	endtask

	// Expiry time for one strap value, sticky until reload
	task automatic t_expire(input logic [3:0] sel);
		int lim;
		lim = (int'(sel) + 1) * 16 * DIV;
		timeout_select_in = sel;
		watchdog_enable_in = 1'b1;
		u_cpu.strobe(8'h80, 1'b1);
		u_cpu.strobe(8'h40, 1'b1);
		chk("run", 16'h1, {15'h0, run});
		repeat (lim - 20) @(negedge clock_in);
		chk("early timeout", 16'h0, {15'h0, tmo});
		repeat (32) @(negedge clock_in);
		chk("timeout", 16'h1, {15'h0, tmo});
		chk("init", 16'h1, {15'h0, init});
		repeat (50) @(negedge clock_in);
		chk("held init", 16'h1, {15'h0, init});
		u_cpu.strobe(8'h80, 1'b1);
		chk("reloaded timeout", 16'h0, {15'h0, tmo});
		chk("reloaded init", 16'h0, {15'h0, init});
	endtask

	// Periodic reload, enable switch, forced init, system clear
	task automatic t_switches();
		timeout_select_in = 4'h0;
		for (int i = 0; i < 5; i++) begin
			repeat (30) @(negedge clock_in);
			u_cpu.strobe(8'h80, 1'b1);
			chk("kept alive", 16'h0, {15'h0, init});
		end
		watchdog_enable_in = 1'b0;
		repeat (110) @(negedge clock_in);
		chk("masked timeout", 16'h1, {15'h0, tmo});
		chk("masked init", 16'h0, {15'h0, init});
		forced_init_in = 1'b1;
		repeat (4) @(negedge clock_in);
		chk("forced init", 16'h1, {15'h0, init});
		forced_init_in = 1'b0;
		system_clear_in = 1'b1;
		repeat (2) @(negedge clock_in);
		system_clear_in = 1'b0;
		repeat (4) @(negedge clock_in);
		chk("clear", 16'h0, {14'h0, tmo, run});
		u_cpu.read_byte(b, ok);
		chk("sync after clear", 16'h0, {15'h0, ok});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog on the run itself
	initial begin
		repeat (10) @(negedge clock_in);
		rst_in = 1'b0;
		repeat (3) @(negedge clock_in);
		t_read();
		t_select();
		t_expire(4'h0);
		t_expire(4'h5);
		t_expire(4'hf);
		t_switches();
		summarize();
	end

	// Whole run is about 4200 cycles; a hang stops well past that
	initial begin
		repeat (40000) @(posedge clock_in);
		num_errors++;
		summarize();
	end
endmodule // boot_rom_loader_watchdog_tb
`default_nettype wire
